// ---- dpsc_pkg.sv ----
`default_nettype none

package dpsc_pkg;

    // ==========================================
    // Widths of the device port.
    localparam int ADDR_W = 16;
    localparam int DATA_W = 9;
    localparam int SEM_SEL_W = 3;

    // ==========================================
    // Cycle counts at 40 MHz, derived from times in ns.
    localparam int CLK_PERIOD_NS = 25;
    localparam int SETUP_NS = 50;
    localparam int PULSE_NS = 50;
    localparam int HOLD_NS = 25;
    localparam logic [3:0] SETUP_CYC = 4'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] PULSE_CYC = 4'((PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] HOLD_CYC = 4'((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // A read strobe also covers the three-stage data synchroniser before the capture.
    localparam logic [3:0] SYNC_CYC = 4'h3;
    localparam logic [3:0] READ_PULSE_CYC = 4'(PULSE_CYC + SYNC_CYC);
    localparam logic [3:0] CNT_RESET = 4'h0;
    localparam logic [3:0] CNT_ONE = 4'h1;

    // ==========================================
    // Sequencer states and commands.
    typedef enum logic [4:0] {
        DPSC_IDLE = 5'h01,
        DPSC_SETUP = 5'h02,
        DPSC_PULSE = 5'h04,
        DPSC_HOLD = 5'h08,
        DPSC_DONE = 5'h10
    } dpsc_state_e;

    typedef enum logic [1:0] {
        DPSC_CMD_CLAIM = 2'h0,
        DPSC_CMD_RELEASE = 2'h1,
        DPSC_CMD_POLL = 2'h2
    } dpsc_cmd_e;

    // ==========================================
    // Pins toward one device port, all active levels as on the part.
    typedef struct packed {
        logic chip_sel_n;
        logic token_space_select_n;
        logic rw_n;
        logic out_en_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq_o;
        logic dq_oe;
    } dpsc_pins_s;

    typedef struct packed {
        logic busy;
        logic granted;
        logic [DATA_W-1:0] rdata;
    } dpsc_result_s;

    localparam logic [DATA_W-1:0] DQ_ZERO = 9'h000;
    localparam logic [DATA_W-1:0] DQ_ONE = 9'h001;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 16'h0000;

endpackage

`default_nettype wire

// ---- dpsc_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

module dpsc_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] stable_out
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] stable;
    } dpsc_sync_s;

    dpsc_sync_s st;
    dpsc_sync_s next_st;

    // ==========================================
    // Three stages; a change counts once stages two and three agree.
    always_comb begin
        next_st = st;
        next_st.s1 = async_in;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < W; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                next_st.stable[i] = st.s3[i];
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign stable_out = st.stable;

endmodule

`default_nettype wire

// ---- dpsc_token_master.sv ----
`timescale 1ns/1ps
`default_nettype none

// Operation
// R1: Master device drives the busy flags; this controller only observes them.
// R2: Slave busy-low inhibits writes; controller reports busy but does not retry writes.
// R3: System uses exactly one master part per width-expanded array.
// R4: Master decides busy from chip select and address only.
// R5: Busy decision ignores read or write direction.
// R6: Address and selects settle before the write pulse starts.
// R7: Eight semaphore latches live apart from the memory array.
// R8: The two ports are independent; neither delays the other.
// R9: Simultaneous semaphore accesses never give ambiguous results.
// R10: Port idles with chip select and token select both high.
// R11: Semaphore state gates no hardware; meaning is software's.
// R12: Semaphore accesses take no wait states.
// R13: Claim is write zero, then read back to confirm.
// R14: After a failed claim, re-read or release and retry later.
// R15: Flags active low; write zero requests, write one releases.
// R16: Token space uses token select low with normal SRAM timing.
// R17: Address bits zero to two pick one of eight semaphores.
// R18: Higher address bits are ignored for semaphore accesses.
// R19: Only data bit zero carries the written semaphore value.
// R20: Read shows the flag on every data bit.
// R21: Read value latched while token select and output enable stay low.
// R22: Pending request gains the token when the holder releases.
module dpsc_token_master (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic cmd_valid_in,
    input wire logic [1:0] cmd_in,
    input wire logic [dpsc_pkg::SEM_SEL_W-1:0] cmd_sem_in,
    input wire logic [dpsc_pkg::DATA_W-1:0] dq_in,
    input wire logic busy_n_in,
    output logic cmd_ready_out,
    output logic done_out,
    output logic granted_out,
    output logic busy_seen_out,
    output logic [dpsc_pkg::DATA_W-1:0] rdata_out,
    output logic chip_sel_n_out,
    output logic token_space_select_n_out,
    output logic rw_n_out,
    output logic out_en_n_out,
    output logic [dpsc_pkg::ADDR_W-1:0] addr_out,
    output logic [dpsc_pkg::DATA_W-1:0] dq_out,
    output logic dq_oe_out
);

    typedef struct packed {
        dpsc_pkg::dpsc_state_e state;
        logic [3:0] cnt;
        logic [1:0] cmd;
        logic claim_read;
        dpsc_pkg::dpsc_pins_s pins;
        dpsc_pkg::dpsc_result_s res;
        logic ready;
        logic done;
    } dpsc_top_s;

    dpsc_top_s st;
    dpsc_top_s next_st;
    logic [dpsc_pkg::DATA_W:0] sync_q;
    logic [3:0] pulse_len;

    // ==========================================
    // Synchronisers for device data and the busy flag.
    // Busy is inverted ahead of the synchroniser so that its reset value reads as not busy.
    dpsc_sync #(
        .W(dpsc_pkg::DATA_W + 1)
    ) u_sync (
        .clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in),
        .async_in({~busy_n_in, dq_in}),
        .stable_out(sync_q)
    );

    // A read strobe stays low until the read data has passed the synchroniser.
    assign pulse_len = st.pins.dq_oe ? dpsc_pkg::PULSE_CYC : dpsc_pkg::READ_PULSE_CYC; // R21

    // ==========================================
    // Access sequencer.
    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        case (st.state)
            dpsc_pkg::DPSC_IDLE: begin
                next_st.pins.chip_sel_n = 1'b1; // R10
                next_st.pins.token_space_select_n = 1'b1; // R10
                next_st.pins.rw_n = 1'b1;
                next_st.pins.out_en_n = 1'b1;
                next_st.pins.dq_oe = 1'b0;
                next_st.ready = 1'b1;
                if (cmd_valid_in && st.ready) begin
                    next_st.ready = 1'b0;
                    next_st.cmd = cmd_in;
                    next_st.claim_read = 1'b0;
                    next_st.res.busy = 1'b0;
                    next_st.pins.addr = dpsc_pkg::ADDR_ZERO;
                    next_st.pins.addr[dpsc_pkg::SEM_SEL_W-1:0] = cmd_sem_in; // R17 R18
                    next_st.pins.token_space_select_n = 1'b0; // R16
                    next_st.pins.chip_sel_n = 1'b1; // R7
                    next_st.pins.dq_o = (cmd_in == dpsc_pkg::DPSC_CMD_CLAIM) ?
                        dpsc_pkg::DQ_ZERO : dpsc_pkg::DQ_ONE; // R15 R19
                    next_st.pins.dq_oe = (cmd_in != dpsc_pkg::DPSC_CMD_POLL);
                    next_st.cnt = dpsc_pkg::CNT_RESET;
                    next_st.state = dpsc_pkg::DPSC_SETUP;
                end
            end
            dpsc_pkg::DPSC_SETUP: begin
                next_st.cnt = st.cnt + dpsc_pkg::CNT_ONE;
                if (st.cnt + dpsc_pkg::CNT_ONE >= dpsc_pkg::SETUP_CYC) begin // R6
                    next_st.cnt = dpsc_pkg::CNT_RESET;
                    next_st.state = dpsc_pkg::DPSC_PULSE;
                    if (st.pins.dq_oe) begin
                        next_st.pins.rw_n = 1'b0;
                    end else begin
                        next_st.pins.out_en_n = 1'b0; // R21
                    end
                end
            end
            dpsc_pkg::DPSC_PULSE: begin
                next_st.cnt = st.cnt + dpsc_pkg::CNT_ONE;
                if (sync_q[dpsc_pkg::DATA_W]) begin
                    next_st.res.busy = 1'b1; // R2 R3
                end
                if (st.cnt + dpsc_pkg::CNT_ONE >= pulse_len) begin // R12
                    next_st.cnt = dpsc_pkg::CNT_RESET;
                    if (!st.pins.dq_oe) begin
                        next_st.res.rdata = sync_q[dpsc_pkg::DATA_W-1:0]; // R20 R21
                        next_st.res.granted = ~sync_q[0]; // R15
                    end
                    next_st.pins.rw_n = 1'b1;
                    next_st.pins.out_en_n = 1'b1;
                    next_st.state = dpsc_pkg::DPSC_HOLD;
                end
            end
            dpsc_pkg::DPSC_HOLD: begin
                next_st.cnt = st.cnt + dpsc_pkg::CNT_ONE;
                if (st.cnt + dpsc_pkg::CNT_ONE >= dpsc_pkg::HOLD_CYC) begin
                    next_st.cnt = dpsc_pkg::CNT_RESET;
                    next_st.pins.dq_oe = 1'b0;
                    if (st.cmd == dpsc_pkg::DPSC_CMD_CLAIM && !st.claim_read) begin
                        next_st.claim_read = 1'b1; // R13
                        next_st.state = dpsc_pkg::DPSC_SETUP;
                    end else begin
                        next_st.pins.token_space_select_n = 1'b1;
                        next_st.state = dpsc_pkg::DPSC_DONE;
                    end
                end
            end
            dpsc_pkg::DPSC_DONE: begin
                next_st.done = 1'b1; // R14 R22
                next_st.state = dpsc_pkg::DPSC_IDLE;
            end
            default: begin
                next_st.state = dpsc_pkg::DPSC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            st <= '0;
            st.state <= dpsc_pkg::DPSC_IDLE;
            st.pins.chip_sel_n <= 1'b1;
            st.pins.token_space_select_n <= 1'b1;
            st.pins.rw_n <= 1'b1;
            st.pins.out_en_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign cmd_ready_out = st.ready;
    assign done_out = st.done;
    assign granted_out = st.res.granted;
    assign busy_seen_out = st.res.busy;
    assign rdata_out = st.res.rdata;
    assign chip_sel_n_out = st.pins.chip_sel_n;
    assign token_space_select_n_out = st.pins.token_space_select_n;
    assign rw_n_out = st.pins.rw_n;
    assign out_en_n_out = st.pins.out_en_n;
    assign addr_out = st.pins.addr;
    assign dq_out = st.pins.dq_o;
    assign dq_oe_out = st.pins.dq_oe;

endmodule

`default_nettype wire

// ---- dpsc_token_master_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module dpsc_checker (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic cmd_valid_in,
    input wire logic [1:0] cmd_in,
    input wire logic cmd_ready_out,
    input wire logic done_out,
    input wire logic granted_out,
    input wire logic [8:0] rdata_out,
    input wire logic token_space_select_n_out,
    input wire logic rw_n_out,
    input wire logic out_en_n_out,
    input wire logic [15:0] addr_out,
    input wire logic [8:0] dq_out,
    input wire logic dq_oe_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);
    sequence s_take;
        cmd_valid_in && cmd_ready_out;
    endsequence
    sequence s_claim_wr;
        !rw_n_out && dq_out[0] == 1'b0 ##1 rw_n_out;
    endsequence
    a_take_done: assert property ((s_take ##0 cmd_in == 2'h0) |-> ##15 done_out) else $error("claim end");
    a_release_done: assert property ((s_take ##0 cmd_in == 2'h1) |-> ##7 done_out) else $error("release end");
    a_poll_done: assert property ((s_take ##0 cmd_in == 2'h2) |-> ##10 done_out) else $error("poll end");
    a_upper_addr: assert property (addr_out[15:3] == 13'h0000) else $error("high address");
    a_setup_first: assert property ($fell(rw_n_out) |-> $past(token_space_select_n_out, 2) == 1'b0
        && $stable(addr_out)) else $error("no setup");
    a_write_bit: assert property (!rw_n_out |-> dq_oe_out && dq_out[8:1] == 8'h00) else $error("wdata");
    a_claim_read: assert property (s_claim_wr |-> ##[1:6] !out_en_n_out) else $error("no readback");
    a_dq_quiet: assert property (token_space_select_n_out |-> !dq_oe_out) else $error("dq driven");
    a_grant_flag: assert property ($rose(granted_out) |-> rdata_out == 9'h000) else $error("grant");
    a_ready_idle: assert property (cmd_ready_out |-> token_space_select_n_out && rw_n_out
        && out_en_n_out) else $error("not idle");
endmodule
bind dpsc_token_master dpsc_checker u_chk (.clk_sys_in, .resetn_in, .cmd_valid_in, .cmd_in, .cmd_ready_out,
    .done_out, .granted_out, .rdata_out, .token_space_select_n_out, .rw_n_out, .out_en_n_out,
    .addr_out, .dq_out, .dq_oe_out);
`default_nettype wire

// ---- dpsc_sem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module dpsc_sem_model (
    input wire logic sel_n_in,
    input wire logic rw_n_in,
    input wire logic oe_n_in,
    input wire logic [15:0] addr_in,
    input wire logic [8:0] dq_ctl_in,
    input wire logic dq_oe_in,
    input wire logic right_wr_in,
    input wire logic [2:0] right_sem_in,
    input wire logic right_bit_in,
    output logic [8:0] dq_out,
    output logic busy_n_out
);
    logic [7:0] req_l = 8'h00, req_r = 8'h00, own_l = 8'h00, own_r = 8'h00;
    logic [8:0] rd_q = 9'h000;
    logic rd_on = 1'b0;
    task automatic put(input logic left, input logic [2:0] i, input logic v);
        if (left) req_l[i] = v;
        else req_r[i] = v;
        if (req_l[i]) own_l[i] = 1'b0;
        if (req_r[i]) own_r[i] = 1'b0;
        if (!req_l[i] && !own_r[i]) own_l[i] = 1'b1;
        if (!req_r[i] && !own_l[i]) own_r[i] = 1'b1;
    endtask
    always @(posedge rw_n_in) if (!sel_n_in) put(1'b1, addr_in[2:0], dq_ctl_in[0]);
    always @(posedge right_wr_in) put(1'b0, right_sem_in, right_bit_in);
    always @(sel_n_in or oe_n_in) begin
        if (!sel_n_in && !oe_n_in && !rd_on) rd_q = {9{~own_l[addr_in[2:0]]}};
        rd_on = !sel_n_in && !oe_n_in;
    end
    assign dq_out = dq_oe_in ? dq_ctl_in : (rd_on ? rd_q : ~rd_q);
    assign busy_n_out = 1'b1;
endmodule
`default_nettype wire

// ---- tb_dual_port_busy_and_semaphore_logic.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_dual_port_busy_and_semaphore_logic;
    logic clk_sys_in = 1'b0, resetn_in = 1'b0, cmd_valid_in = 1'b0, r_wr = 1'b0, r_bit = 1'b1;
    logic [1:0] cmd_in = 2'h2;
    logic [2:0] cmd_sem_in = 3'h0, r_sem = 3'h0, s;
    logic [8:0] dq_in, rdata_out, dq_out;
    logic busy_n_in, cmd_ready_out, done_out, granted_out, busy_seen_out, chip_sel_n_out;
    logic token_space_select_n_out, rw_n_out, out_en_n_out, dq_oe_out;
    logic [15:0] addr_out;
    int errors = 0, cmp_count = 0, seed;
    dpsc_token_master u_dut (.clk_sys_in, .resetn_in, .cmd_valid_in, .cmd_in, .cmd_sem_in, .dq_in,
        .busy_n_in, .cmd_ready_out, .done_out, .granted_out, .busy_seen_out, .rdata_out, .chip_sel_n_out,
        .token_space_select_n_out, .rw_n_out, .out_en_n_out, .addr_out, .dq_out, .dq_oe_out);
    dpsc_sem_model u_dev (.sel_n_in(token_space_select_n_out), .rw_n_in(rw_n_out), .oe_n_in(out_en_n_out),
        .addr_in(addr_out), .dq_ctl_in(dq_out), .dq_oe_in(dq_oe_out), .right_wr_in(r_wr),
        .right_sem_in(r_sem), .right_bit_in(r_bit), .dq_out(dq_in), .busy_n_out(busy_n_in));
    initial begin
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end
    function automatic logic [8:0] word(input logic held);
        return held ? 9'h000 : 9'h1FF;
    endfunction
    task automatic stop_test;
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic run(input logic [1:0] c, input logic [2:0] i);
        int n;
        n = 0;
        while (cmd_ready_out !== 1'b1 || n == 0) begin
            @(negedge clk_sys_in);
            n++;
            if (n > 40) chk(9'h000, 9'h001);
            if (n > 40) stop_test();
        end
        @(posedge clk_sys_in);
        cmd_valid_in <= 1'b1;
        cmd_in <= c;
        cmd_sem_in <= i;
        @(posedge clk_sys_in);
        cmd_valid_in <= 1'b0;
        n = 0;
        while (done_out !== 1'b1) begin
            @(negedge clk_sys_in);
            n++;
            if (n > 40) chk(9'h000, 9'h002);
            if (n > 40) stop_test();
        end
    endtask
    task automatic rwr(input logic [2:0] i, input logic b);
        @(posedge clk_sys_in);
        r_sem <= i;
        r_bit <= b;
        r_wr <= 1'b1;
        @(posedge clk_sys_in);
        r_wr <= 1'b0;
    endtask
    initial begin
        seed = 32'h7b3b;
        repeat (6) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            run(2'h1, 3'(i));
            rwr(3'(i), 1'b1);
        end
        repeat (4) begin
            s = 3'($random(seed));
            run(2'h0, s);
            chk(rdata_out, word(1'b1));
            chk({8'h00, granted_out}, 9'h001);
            rwr(s, 1'b0);
            run(2'h2, s);
            chk(rdata_out, word(1'b1));
            run(2'h1, s);
            run(2'h2, s);
            chk(rdata_out, word(1'b0));
            run(2'h0, s);
            chk({8'h00, granted_out}, 9'h000);
            run(2'h2, s);
            chk(rdata_out, word(1'b0));
            rwr(s, 1'b1);
            run(2'h2, s);
            chk(rdata_out, word(1'b1));
            run(2'h2, s ^ 3'h1);
            chk(rdata_out, word(1'b0));
            chk({8'h00, busy_seen_out}, 9'h000);
            chk({8'h00, chip_sel_n_out}, 9'h001);
            run(2'h1, s);
        end
        stop_test();
    end
endmodule
`default_nettype wire
